//--- design/sensor_cfg_pkg.sv
// Constants for the sensor threshold, wait and sample-period register bank.
// Assumes a 25 MHz core clock and 32-bit AXI4-Lite register access.
package sensor_cfg_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_ENABLE = 8'h80;
    localparam logic [7:0] IDX_PROX_SAMPLE_PERIOD = 8'h82;
    localparam logic [7:0] IDX_ALS_WAIT_TIME = 8'h83;
    localparam logic [7:0] IDX_ALS_LOW_THRESH_LO = 8'h84;
    localparam logic [7:0] IDX_ALS_LOW_THRESH_HI = 8'h85;
    localparam logic [7:0] IDX_ALS_HIGH_THRESH_LO = 8'h86;
    localparam logic [7:0] IDX_ALS_HIGH_THRESH_HI = 8'h87;
    localparam logic [7:0] IDX_PROX_LOW_THRESH = 8'h88;
    localparam logic [7:0] IDX_PROX_HIGH_THRESH = 8'h8A;
    localparam logic [7:0] IDX_PERSIST = 8'h8C;
    localparam logic [7:0] IDX_CONFIG0 = 8'h8D;
    localparam logic [7:0] IDX_INT_STATUS = 8'hE0;
    localparam logic [7:0] IDX_INT_MASK = 8'hE1;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_PROX_SAMPLE_PERIOD = 8'h1F;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_CONFIG0 = 8'h80;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int EN_PON_BIT = 0;
    localparam int EN_AEN_BIT = 1;
    localparam int EN_PEN_BIT = 2;
    localparam int EN_WEN_BIT = 3;
    localparam int CFG0_WLONG_BIT = 2;
    localparam int INT_ALS_BIT = 0;
    localparam int INT_PROX_BIT = 1;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int PROX_UNIT_NS = 88000;
    localparam int PROX_UNIT_CYCLES = PROX_UNIT_NS / CLK_PERIOD_NS;
    localparam int INTEG_PERIOD_PS = 1375000;
    localparam int INTEG_CYCLES = INTEG_PERIOD_PS / (CLK_PERIOD_NS * 1000);
    localparam int INTEG_PER_STEP = 2048;
    localparam int WAIT_LONG_FACTOR = 12;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- design/sensor_threshold_wait_config.sv
// Register bank with threshold comparison, persistence filters, wait timer
// and proximity sample-period timer for an optical sensing device.
// Assumes results arrive from same-clock converter logic with a valid pulse
// and that software uses AXI4-Lite with one access of each kind in flight.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
module sensor_threshold_wait_config
    import sensor_cfg_pkg::*;
#(
    parameter int INTEG_DIV = (INTEG_CYCLES < 1) ? 1 : INTEG_CYCLES, // Core clocks per integ tick
    parameter int STEP_TICKS = INTEG_PER_STEP // Integration ticks per wait step
)
(
    input wire logic core_clk,
    input wire logic rst,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [11:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [11:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Converter results
    input wire logic [15:0] clear_result,
    input wire logic clear_result_valid,
    input wire logic [7:0] prox_result,
    input wire logic prox_result_valid,
    // Sequencer handshakes
    input wire logic als_cycle_done,
    output logic wait_active,
    output logic wait_done,
    output logic prox_sample_tick,
    // Interrupt
    output logic irq
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Word index from a byte address; low two bits ignored
    function automatic logic [7:0] word_index(input logic [11:0] addr);
        word_index = addr[9:2];
    endfunction

    // Consecutive out-of-range results needed by a light setting
    function automatic logic [5:0] als_needed(input logic [3:0] setting);
        if (setting < 4'h4)
        begin
            als_needed = {2'h0, setting};
        end
        else
        begin
            als_needed = 6'(setting - 4'h3) * 6'h05;
        end
    endfunction

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [7:0] enable_reg; // Power, function and wait enables
    logic [7:0] prox_sample_period_reg;
    logic [7:0] als_wait_time_reg;
    logic [15:0] als_low_thresh_reg; // Applied sixteen-bit low threshold
    logic [15:0] als_high_thresh_reg; // Applied sixteen-bit high threshold
    logic [7:0] low_byte_latch_reg; // Pending low byte, shared by both pairs
    logic [7:0] prox_low_thresh_reg;
    logic [7:0] prox_high_thresh_reg;
    logic [7:0] persist_reg; // Proximity [7:4], light [3:0]
    logic [7:0] config0_reg;
    logic [1:0] int_status_reg; // Sticky event flags
    logic [1:0] int_mask_reg; // Interrupt enables

    // ----------------------------------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------------------------------
    logic aw_full_reg; // Address held, waiting for data
    logic w_full_reg; // Data held, waiting for address
    logic [11:0] aw_addr_reg;
    logic [7:0] w_data_reg;
    logic w_lane0_reg; // Byte lane zero strobe

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
    wire [7:0] wr_idx = word_index(aw_addr_reg);
    wire wr_en = wr_fire && w_lane0_reg;

    // A channel is refused only while its own item is held
    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready = !w_full_reg;

    // Write decode: index check, one low-byte strobe shared by both pairs, high-byte and status strobes
    wire wr_idx_ok = (wr_idx == IDX_ENABLE) || (wr_idx == IDX_PROX_SAMPLE_PERIOD)
        || (wr_idx == IDX_ALS_WAIT_TIME) || (wr_idx == IDX_ALS_LOW_THRESH_LO)
        || (wr_idx == IDX_ALS_LOW_THRESH_HI) || (wr_idx == IDX_ALS_HIGH_THRESH_LO)
        || (wr_idx == IDX_ALS_HIGH_THRESH_HI) || (wr_idx == IDX_PROX_LOW_THRESH)
        || (wr_idx == IDX_PROX_HIGH_THRESH) || (wr_idx == IDX_PERSIST)
        || (wr_idx == IDX_CONFIG0) || (wr_idx == IDX_INT_STATUS)
        || (wr_idx == IDX_INT_MASK);
    wire wr_lo_latch = wr_en && ((wr_idx == IDX_ALS_LOW_THRESH_LO)
        || (wr_idx == IDX_ALS_HIGH_THRESH_LO));
    wire wr_low_hi = wr_en && (wr_idx == IDX_ALS_LOW_THRESH_HI);
    wire wr_high_hi = wr_en && (wr_idx == IDX_ALS_HIGH_THRESH_HI);
    wire wr_status = wr_en && (wr_idx == IDX_INT_STATUS);

    // Hold address and data until both are present
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            else if (wr_fire)
            begin
                aw_full_reg <= 1'b0;
            end
            if (w_take)
            begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata[7:0];
                w_lane0_reg <= s_axi_wstrb[0];
            end
            else if (wr_fire)
            begin
                w_full_reg <= 1'b0;
            end
        end
    end

    // Write response follows both halves
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_idx_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Plain configuration registers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            enable_reg <= RST_ZERO;
            prox_sample_period_reg <= RST_PROX_SAMPLE_PERIOD;
            als_wait_time_reg <= RST_ZERO;
            prox_low_thresh_reg <= RST_ZERO;
            prox_high_thresh_reg <= RST_ZERO;
            persist_reg <= RST_ZERO;
            config0_reg <= RST_CONFIG0;
            int_mask_reg <= 2'h0;
        end
        else if (wr_en)
        begin
            case (wr_idx)
                IDX_ENABLE: enable_reg <= w_data_reg;
                IDX_PROX_SAMPLE_PERIOD: prox_sample_period_reg <= w_data_reg;
                IDX_ALS_WAIT_TIME: als_wait_time_reg <= w_data_reg;
                IDX_PROX_LOW_THRESH: prox_low_thresh_reg <= w_data_reg;
                IDX_PROX_HIGH_THRESH: prox_high_thresh_reg <= w_data_reg;
                IDX_PERSIST: persist_reg <= w_data_reg;
                IDX_CONFIG0: config0_reg <= w_data_reg;
                IDX_INT_MASK: int_mask_reg <= w_data_reg[1:0];
                default: ; // Other indices handled elsewhere or unmapped
            endcase
        end
    end

    // Light thresholds: a high-byte write applies the latched low byte
    // to its own pair, whichever low byte was written last
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            low_byte_latch_reg <= RST_ZERO;
            als_low_thresh_reg <= {RST_ZERO, RST_ZERO};
            als_high_thresh_reg <= {RST_ZERO, RST_ZERO};
        end
        else
        begin
            if (wr_lo_latch)
            begin
                low_byte_latch_reg <= w_data_reg;
            end
            if (wr_low_hi)
            begin
                als_low_thresh_reg <= {w_data_reg, low_byte_latch_reg};
            end
            if (wr_high_hi)
            begin
                als_high_thresh_reg <= {w_data_reg, low_byte_latch_reg};
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------------------------------
    wire [7:0] rd_idx = word_index(s_axi_araddr);
    wire [7:0] rd_byte =
        (rd_idx == IDX_ENABLE) ? enable_reg :
        (rd_idx == IDX_PROX_SAMPLE_PERIOD) ? prox_sample_period_reg :
        (rd_idx == IDX_ALS_WAIT_TIME) ? als_wait_time_reg :
        (rd_idx == IDX_ALS_LOW_THRESH_LO) ? als_low_thresh_reg[7:0] :
        (rd_idx == IDX_ALS_LOW_THRESH_HI) ? als_low_thresh_reg[15:8] :
        (rd_idx == IDX_ALS_HIGH_THRESH_LO) ? als_high_thresh_reg[7:0] :
        (rd_idx == IDX_ALS_HIGH_THRESH_HI) ? als_high_thresh_reg[15:8] :
        (rd_idx == IDX_PROX_LOW_THRESH) ? prox_low_thresh_reg :
        (rd_idx == IDX_PROX_HIGH_THRESH) ? prox_high_thresh_reg :
        (rd_idx == IDX_PERSIST) ? persist_reg :
        (rd_idx == IDX_CONFIG0) ? config0_reg :
        (rd_idx == IDX_INT_STATUS) ? {6'h00, int_status_reg} :
        (rd_idx == IDX_INT_MASK) ? {6'h00, int_mask_reg} : 8'h00;
    wire rd_idx_ok = (rd_idx == IDX_ENABLE) || (rd_idx == IDX_PROX_SAMPLE_PERIOD)
        || (rd_idx == IDX_ALS_WAIT_TIME) || (rd_idx == IDX_ALS_LOW_THRESH_LO)
        || (rd_idx == IDX_ALS_LOW_THRESH_HI) || (rd_idx == IDX_ALS_HIGH_THRESH_LO)
        || (rd_idx == IDX_ALS_HIGH_THRESH_HI) || (rd_idx == IDX_PROX_LOW_THRESH)
        || (rd_idx == IDX_PROX_HIGH_THRESH) || (rd_idx == IDX_PERSIST)
        || (rd_idx == IDX_CONFIG0) || (rd_idx == IDX_INT_STATUS)
        || (rd_idx == IDX_INT_MASK);

    // One read at a time; address refused while data is pending
    assign s_axi_arready = !s_axi_rvalid;

    // Register the read answer
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_idx_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Threshold compare and persistence
    // ----------------------------------------------------------------
    wire powered = enable_reg[EN_PON_BIT];
    wire als_on = powered && enable_reg[EN_AEN_BIT];
    wire prox_on = powered && enable_reg[EN_PEN_BIT];

    // Strict compares: equality is in range
    wire als_out = (clear_result < als_low_thresh_reg)
        || (clear_result > als_high_thresh_reg);
    wire prox_out = (prox_result < prox_low_thresh_reg)
        || (prox_result > prox_high_thresh_reg);

    logic [5:0] als_run_reg; // Consecutive out-of-range light results
    logic [3:0] prox_run_reg; // Consecutive out-of-range proximity results
    wire [5:0] als_need = als_needed(persist_reg[3:0]);
    wire [3:0] prox_need = persist_reg[7:4];
    wire [5:0] als_run_next = als_out ? ((als_run_reg == 6'h3F) ? als_run_reg
        : als_run_reg + 6'h01) : 6'h00;
    wire [3:0] prox_run_next = prox_out ? ((prox_run_reg == 4'hF) ? prox_run_reg
        : prox_run_reg + 4'h1) : 4'h0;

    // Setting zero fires on every result; otherwise the run must reach it
    wire als_event = als_on && clear_result_valid
        && ((als_need == 6'h00) || (als_out && (als_run_next >= als_need)));
    wire prox_event = prox_on && prox_result_valid
        && ((prox_need == 4'h0) || (prox_out && (prox_run_next >= prox_need)));

    // Track the persistence runs
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            als_run_reg <= 6'h00;
            prox_run_reg <= 4'h0;
        end
        else
        begin
            if (!als_on)
            begin
                als_run_reg <= 6'h00;
            end
            else if (clear_result_valid)
            begin
                als_run_reg <= als_run_next;
            end
            if (!prox_on)
            begin
                prox_run_reg <= 4'h0;
            end
            else if (prox_result_valid)
            begin
                prox_run_reg <= prox_run_next;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status: set wins over write-one-to-clear
    // ----------------------------------------------------------------
    wire [1:0] int_set = {prox_event, als_event};
    wire [1:0] int_clr = wr_status ? w_data_reg[1:0] : 2'h0;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            int_status_reg <= 2'h0;
        end
        else
        begin
            int_status_reg <= (int_status_reg & ~int_clr) | int_set;
        end
    end

    // Pin follows only enabled flags
    assign irq = |(int_status_reg & int_mask_reg);

    // ----------------------------------------------------------------
    // Integration clock enable and wait timer
    // ----------------------------------------------------------------
    logic [7:0] integ_div_reg; // Core clocks within one integration tick
    logic [11:0] step_tick_reg; // Integration ticks within one step
    logic [3:0] long_rep_reg; // Repeats of one step under long wait
    logic [7:0] wait_count_reg; // Down counter, zero is terminal
    wire integ_tick = (integ_div_reg == 8'(INTEG_DIV - 1));
    wire step_end = integ_tick && (step_tick_reg == 12'(STEP_TICKS - 1));
    wire wlong = config0_reg[CFG0_WLONG_BIT];
    wire [3:0] rep_last = wlong ? 4'(WAIT_LONG_FACTOR - 1) : 4'h0;
    wire unit_end = step_end && (long_rep_reg == rep_last);
    wire wait_start = als_cycle_done && powered && enable_reg[EN_WEN_BIT] && !wait_active;

    // Free-running divider that models the integration clock
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            integ_div_reg <= 8'h00;
        end
        else
        begin
            integ_div_reg <= integ_tick ? 8'h00 : integ_div_reg + 8'h01;
        end
    end

    // Wait sequence: load, count units (one step, or twelve under long wait) down to zero, then end
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wait_active <= 1'b0;
            wait_done <= 1'b0;
            wait_count_reg <= 8'h00;
            step_tick_reg <= 12'h000;
            long_rep_reg <= 4'h0;
        end
        else
        begin
            wait_done <= 1'b0;
            if (wait_start)
            begin
                // Step phase restarts; the free-running divider phase can shorten the first tick
                wait_active <= 1'b1;
                wait_count_reg <= als_wait_time_reg;
                step_tick_reg <= 12'h000;
                long_rep_reg <= 4'h0;
            end
            else if (wait_active && !powered)
            begin
                wait_active <= 1'b0; // Oscillator off aborts the wait
            end
            else if (wait_active && integ_tick)
            begin
                step_tick_reg <= step_end ? 12'h000 : step_tick_reg + 12'h001;
                if (step_end)
                begin
                    long_rep_reg <= unit_end ? 4'h0 : long_rep_reg + 4'h1;
                end
                if (unit_end && (wait_count_reg == 8'h00))
                begin
                    wait_active <= 1'b0;
                    wait_done <= 1'b1;
                end
                else if (unit_end)
                begin
                    wait_count_reg <= wait_count_reg - 8'h01;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Proximity sample-period timer
    // ----------------------------------------------------------------
    logic [11:0] prox_unit_reg; // Core clocks within one 88 us unit
    logic [7:0] prox_units_reg; // Units elapsed in this sample
    wire prox_unit_end = (prox_unit_reg == 12'(PROX_UNIT_CYCLES - 1));
    wire prox_period_end = prox_unit_end && (prox_units_reg == prox_sample_period_reg);

    // Emits one tick per sample; restarts when proximity is off
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            prox_unit_reg <= 12'h000;
            prox_units_reg <= 8'h00;
            prox_sample_tick <= 1'b0;
        end
        else if (!prox_on)
        begin
            prox_unit_reg <= 12'h000;
            prox_units_reg <= 8'h00;
            prox_sample_tick <= 1'b0;
        end
        else
        begin
            prox_unit_reg <= prox_unit_end ? 12'h000 : prox_unit_reg + 12'h001;
            prox_sample_tick <= prox_period_end;
            if (prox_period_end)
            begin
                prox_units_reg <= 8'h00;
            end
            else if (prox_unit_end)
            begin
                prox_units_reg <= prox_units_reg + 8'h01;
            end
        end
    end

endmodule

//--- test/sensor_cfg_chk.sv
// Port checker for the sensor register bank.
// Assumes the single core_clk domain and active-high rst.
`timescale 1ns/1ns
module sensor_cfg_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic als_cycle_done,
    input wire logic wait_active,
    input wire logic wait_done
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Both halves of a write taken at one edge
    sequence w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    chk_w_answer: assert property (w_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    chk_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_done_end: assert property (wait_done |-> $fell(wait_active))
        else $error("wait end pulse misplaced");
    chk_wait_start: assert property ($rose(wait_active) |-> $past(als_cycle_done))
        else $error("wait started without cycle end");
endmodule
bind sensor_threshold_wait_config sensor_cfg_chk chk_i (.*);

//--- test/result_source.sv
// Converter stand-in feeding results to the bank.
// Assumes callers enter its tasks just after a rising edge.
`timescale 1ns/1ns
module result_source (
    input wire logic core_clk,
    output logic [15:0] clear_result,
    output logic clear_result_valid,
    output logic [7:0] prox_result,
    output logic prox_result_valid
);
    initial
    begin
        {clear_result, clear_result_valid, prox_result, prox_result_valid} = '0;
    end
    // Data inverted after the pulse so a stale value never passes as valid
    task automatic light(input logic [15:0] v);
        clear_result <= v;
        clear_result_valid <= 1'b1;
        @(posedge core_clk);
        clear_result_valid <= 1'b0;
        clear_result <= ~v;
    endtask
    task automatic prox(input logic [7:0] v);
        prox_result <= v;
        prox_result_valid <= 1'b1;
        @(posedge core_clk);
        prox_result_valid <= 1'b0;
        prox_result <= ~v;
    endtask
endmodule

//--- test/testbench.sv
// Self-checking bench for the sensor bank over AXI4-Lite.
// Assumes short wait steps: 2 clocks per tick, 4 ticks per step.
`timescale 1ns/1ns
module testbench;
    import sensor_cfg_pkg::*;
    logic core_clk = 0, rst = 1, als_cycle_done = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_rvalid, wait_active, wait_done, prox_sample_tick, irq;
    logic [15:0] clear_result;
    logic [7:0] prox_result;
    logic clear_result_valid, prox_result_valid;
    logic [7:0] ix [8] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h8A};
    int fail_count = 0, checked = 0, cycles = 0, n;
    sensor_threshold_wait_config #(.INTEG_DIV(2), .STEP_TICKS(4)) uut (.*);
    result_source src (.core_clk, .clear_result, .clear_result_valid, .prox_result,
        .prox_result_valid);
    always #20 core_clk = ~core_clk;
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic wr(input logic [7:0] i, input logic [7:0] v);
        logic a = 1, w = 1;
        s_axi_awaddr <= {2'h0, i, 2'h0};
        s_axi_wdata <= {24'h0, v};
        while (a || w)
        begin
            s_axi_awvalid <= a;
            s_axi_wvalid <= w;
            @(negedge core_clk);
            a = a && !s_axi_awready;
            w = w && !s_axi_wready;
            @(posedge core_clk);
        end
        s_axi_awvalid <= 0;
        s_axi_wvalid <= 0;
        do @(negedge core_clk); while (!s_axi_bvalid);
        cmp({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
        @(posedge core_clk);
        s_axi_bready <= 1;
        @(posedge core_clk);
        s_axi_bready <= 0;
    endtask
    task automatic chk_rd(input logic [7:0] i, input logic [7:0] e);
        s_axi_araddr <= {2'h0, i, 2'h0};
        s_axi_arvalid <= 1;
        do @(negedge core_clk); while (!s_axi_arready);
        @(posedge core_clk);
        s_axi_arvalid <= 0;
        do @(negedge core_clk); while (!s_axi_rvalid);
        r = s_axi_rresp;
        cmp(s_axi_rdata, {24'h0, e});
        @(posedge core_clk);
        s_axi_rready <= 1;
        @(posedge core_clk);
        s_axi_rready <= 0;
    endtask
    // Send a result, then look at the interrupt pin once settled
    task automatic res(input logic p, input logic [15:0] v, input logic e);
        if (p)
            src.prox(v[7:0]);
        else
            src.light(v);
        repeat (3) @(negedge core_clk);
        cmp({31'h0, irq}, {31'h0, e});
        @(posedge core_clk);
    endtask
    // Wait length in clocks; divider phase may take one off
    task automatic wait_len(input int e);
        als_cycle_done <= 1;
        @(posedge core_clk);
        als_cycle_done <= 0;
        n = 0;
        @(negedge core_clk);
        while (wait_active === 1'b1)
        begin
            n++;
            @(negedge core_clk);
        end
        cmp(32'(n >= e - 1 && n <= e), 32'h1);
        cmp({31'h0, wait_done}, 32'h1);
        @(posedge core_clk);
    endtask
    initial
    begin
        repeat (20) @(posedge core_clk);
        rst <= 0;
        foreach (ix[k]) chk_rd(ix[k], ix[k] == 8'h82 ? 8'h1F : 8'h00);
        chk_rd(8'h90, 8'h00);
        cmp({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h84, 8'h34);
        chk_rd(8'h84, 8'h00);
        wr(8'h87, 8'h12);
        chk_rd(8'h86, 8'h34);
        chk_rd(8'h87, 8'h12);
        wr(8'h84, 8'h10);
        wr(8'h85, 8'h00);
        chk_rd(8'h84, 8'h10);
        $display("register test end");
        wr(8'h82, 8'h01);
        wr(8'h88, 8'h20);
        wr(8'h8A, 8'h80);
        wr(8'h8C, 8'h11);
        wr(8'hE1, 8'h03);
        wr(8'h80, 8'h0F);
        res(0, 16'h0010, 0);
        res(0, 16'h1234, 0);
        res(0, 16'h000F, 1);
        chk_rd(8'hE0, 8'h01);
        wr(8'hE0, 8'h01);
        res(0, 16'h1235, 1);
        wr(8'hE0, 8'h01);
        res(1, 16'h0020, 0);
        res(1, 16'h001F, 1);
        wr(8'hE0, 8'h02);
        res(1, 16'h0081, 1);
        wr(8'hE0, 8'h02);
        wr(8'h8C, 8'h13);
        res(0, 16'h0010, 0);
        res(0, 16'h0000, 0);
        res(0, 16'h0000, 0);
        res(0, 16'h0000, 1);
        wr(8'hE0, 8'h01);
        wr(8'hE1, 8'h00);
        res(0, 16'h0000, 0);
        chk_rd(8'hE0, 8'h01);
        $display("threshold test end");
        wr(8'h83, 8'h01);
        wait_len(16);
        wr(8'h8D, 8'h84);
        wait_len(192);
        do @(negedge core_clk); while (prox_sample_tick !== 1'b1);
        n = 0;
        do begin n++; @(negedge core_clk); end while (prox_sample_tick !== 1'b1);
        cmp(n, 2 * PROX_UNIT_CYCLES);
        $display("timer test end");
        give_verdict();
    end
endmodule
